// file: xps_crosspoint.sv
// Routing core of the 16 input, 8 output crosspoint configuration logic.
// Assumes the serial pins come from the controller on its own clock,
// the strobe and override pins are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "xps_map.svh"

module xps_crosspoint
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic link_sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire xps_pkg::xps_mode_e mode,
    input wire logic cfg,
    input wire logic shutdown,
    input wire logic broadcast_input_zero,
    output logic [`XPS_N_OUT*`XPS_IN_BITS-1:0] route_sel,
    output logic [`XPS_N_OUT-1:0] route_oe_n,
    output logic dout
);
    import xps_pkg::*;

    // =====================================================
    // Declarations
    xps_link_if lnk ();

    logic [3:0] sync_meta;
    logic [3:0] sync_q;
    logic [3:0] sync_in;

    logic cfg_s;
    logic shut_s;
    logic bzero_s;
    logic tgl_s;

    logic cfg_prev;
    logic cfg_rise;
    logic tgl_prev;
    logic tgl_seen;
    logic dirty;
    logic load;

    logic [`XPS_N_OUT*`XPS_IN_BITS-1:0] bank_sel;
    logic [`XPS_N_OUT-1:0] bank_off;

    // =====================================================
    // Serial shift bank on the link clock
    xps_shift u_shift
    (
        .link_sclk (link_sclk),
        .reset_n (reset_n),
        .cs_n (cs_n),
        .din (din),
        .mode (mode),
        .lnk (lnk.shifter)
    );

    // Chain output is the oldest bit of the shift bank
    assign dout = lnk.dout; // RULE19

    // =====================================================
    // Synchronisers for pins and the change toggle
    assign sync_in[`XPS_SY_CFG] = cfg;
    assign sync_in[`XPS_SY_SHUT] = shutdown;
    assign sync_in[`XPS_SY_BZERO] = broadcast_input_zero;
    assign sync_in[`XPS_SY_TGL] = lnk.new_tgl;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync_meta <= 4'h0;
            sync_q <= 4'h0;
        end
        else
        begin
            sync_meta <= sync_in;
            sync_q <= sync_meta;
        end
    end

    assign cfg_s = sync_q[`XPS_SY_CFG];
    assign shut_s = sync_q[`XPS_SY_SHUT];
    assign bzero_s = sync_q[`XPS_SY_BZERO];
    assign tgl_s = sync_q[`XPS_SY_TGL];

    // =====================================================
    // Strobe edge detect; chip select plays no part here
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            cfg_prev <= 1'b0;
        else
            cfg_prev <= cfg_s;
    end

    assign cfg_rise = cfg_s && !cfg_prev; // RULE6

    // =====================================================
    // New data tracking
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            tgl_prev <= 1'b0;
        else
            tgl_prev <= tgl_s;
    end

    assign tgl_seen = tgl_s != tgl_prev;

    // A change seen in the same cycle as a load keeps the flag set
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            dirty <= 1'b0;
        else if (tgl_seen)
            dirty <= 1'b1;
        else if (load)
            dirty <= 1'b0; // RULE7
    end

    // In addressed mode the bank is quiet once its toggle has been synchronised; serial frames flip it every bit
    assign load = cfg_rise && dirty; // RULE5 RULE7

    // =====================================================
    // Active routing registers, one per output
    for (genvar n = 0; n < `XPS_N_OUT; n++)
    begin : g_out
        xps_route_s act;
        xps_route_s staged;

        assign staged = lnk.bank[n*`XPS_ENTRY_BITS +: `XPS_ENTRY_BITS]; // RULE9

        // Shutdown wins over broadcast, both over the strobe
        always_ff @(posedge clk_sys)
        begin
            if (!reset_n)
                act <= `XPS_RST_ENTRY; // RULE20
            else if (shut_s)
                act <= `XPS_RST_ENTRY; // RULE17
            else if (bzero_s)
                act <= `XPS_BZERO_ENTRY; // RULE18
            else if (load)
                act <= staged; // RULE5 RULE8
        end

        assign route_sel[n*`XPS_IN_BITS +: `XPS_IN_BITS] = act.in_addr; // RULE12
        assign route_oe_n[n] = act.off; // RULE13

        assign bank_sel[n*`XPS_IN_BITS +: `XPS_IN_BITS] = staged.in_addr;
        assign bank_off[n] = staged.off;
    end

    // =====================================================
    // Checks on the routing core
    chk_shutdown_all_off: assert property ( // RULE17
        @(posedge clk_sys) disable iff (!reset_n)
        shut_s
        |=> (route_oe_n == {`XPS_N_OUT{1'b1}}) && (route_sel == '0))
        else $error("shutdown did not turn all outputs off");

    chk_broadcast_zero_on: assert property ( // RULE18
        @(posedge clk_sys) disable iff (!reset_n)
        (bzero_s && !shut_s)
        |=> (route_oe_n == '0) && (route_sel == '0))
        else $error("broadcast did not route input zero to all outputs");

    chk_hold_without_cfg: assert property ( // RULE5
        @(posedge clk_sys) disable iff (!reset_n)
        (!cfg_rise && !shut_s && !bzero_s)
        |=> $stable(route_sel) && $stable(route_oe_n))
        else $error("routing changed without a strobe");

    chk_repeat_cfg_idle: assert property ( // RULE7
        @(posedge clk_sys) disable iff (!reset_n)
        (cfg_rise && !dirty && !shut_s && !bzero_s)
        |=> $stable(route_sel) && $stable(route_oe_n))
        else $error("strobe without new data changed routing");

    chk_cfg_loads_bank: assert property ( // RULE8
        @(posedge clk_sys) disable iff (!reset_n)
        (load && !shut_s && !bzero_s)
        |=> (route_sel == $past(bank_sel)) && (route_oe_n == $past(bank_off)))
        else $error("strobe did not copy the shift bank");

    chk_change_marks_dirty: assert property ( // RULE7
        @(posedge clk_sys) disable iff (!reset_n)
        tgl_seen |=> dirty)
        else $error("new data not flagged");

    chk_load_clears_dirty: assert property ( // RULE7
        @(posedge clk_sys) disable iff (!reset_n)
        (load && !tgl_seen) |=> !dirty)
        else $error("load left the new data flag set");

    chk_cfg_pulse_once: assert property ( // RULE6
        @(posedge clk_sys) disable iff (!reset_n)
        (load && !tgl_seen) ##1 cfg_s [*2] |-> !load)
        else $error("one strobe pulse loaded twice");

    chk_reset_all_off: assert property ( // RULE20
        @(posedge clk_sys)
        !reset_n |=> (route_oe_n == {`XPS_N_OUT{1'b1}}) && (route_sel == '0))
        else $error("reset left an output on");

endmodule : xps_crosspoint

`default_nettype wire

// file: xps_map.svh
// Constants of the crosspoint serial configuration block.
// Assumes nothing; included by the package and the design modules.
// Summary of operation
// RULE1 - Chip select high ignores clock and data
// RULE2 - First rising clock arms, next falling captures
// RULE3 - Input bits sampled only on falling edges
// RULE4 - Controller ends frame by select or clock stop
// RULE5 - Routing changes only on configuration strobe
// RULE6 - Configuration strobe ignores chip select level
// RULE7 - Repeated strobes without new data change nothing
// RULE8 - Hidden active register per output drives matrix
// RULE9 - Matching shift bank loaded only serially
// RULE10 - Mode high: word updates one addressed output
// RULE11 - Mode low: 40-bit frame sets all outputs
// RULE12 - One input per output, inputs shareable
// RULE13 - Output marked off is not driven
// RULE14 - Controller never enables two joined outputs
// RULE15 - Frame: five bits per output, LSB first
// RULE16 - Word: output, input, off flag, LSB first
// RULE17 - Shutdown pin: all outputs off, input zero
// RULE18 - Broadcast pin: all outputs on, input zero
// RULE19 - Oldest shifted bit appears on serial output
// RULE20 - Reset leaves every output off
`ifndef XPS_MAP_SVH
`define XPS_MAP_SVH

// =====================================================
// Geometry
`define XPS_N_OUT 8
`define XPS_IN_BITS 4
`define XPS_ENTRY_BITS 5
`define XPS_FRAME_BITS 40
`define XPS_WORD_LAST 3'h7

// =====================================================
// Addressed word fields
`define XPS_AW_OUT_LSB 0
`define XPS_AW_IN_LSB 3

// =====================================================
// Entry values: off flag in bit 4, input address below
`define XPS_RST_ENTRY 5'h10
`define XPS_BZERO_ENTRY 5'h00

// =====================================================
// Synchroniser lanes
`define XPS_SY_CFG 0
`define XPS_SY_SHUT 1
`define XPS_SY_BZERO 2
`define XPS_SY_TGL 3

`endif

// file: xps_pkg.sv
// Types shared by the crosspoint configuration modules.
// Assumes xps_map.svh is on the include path.
`include "xps_map.svh"

package xps_pkg;

    typedef enum logic
    {
        XPS_MODE_SERIAL = 1'b0,
        XPS_MODE_ADDR = 1'b1
    } xps_mode_e;

    typedef struct packed
    {
        logic off;
        logic [`XPS_IN_BITS-1:0] in_addr;
    } xps_route_s;

    typedef logic [`XPS_FRAME_BITS-1:0] xps_bank_t;

endpackage : xps_pkg

// file: xps_link_if.sv
// Carrier between the serial shifter and the routing core.
// Assumes the shifter drives every signal from link clock flops.
`timescale 1ns/1ps
`default_nettype none

interface xps_link_if;
    xps_pkg::xps_bank_t bank;
    logic new_tgl;
    logic dout;

    modport shifter (output bank, output new_tgl, output dout);
    modport core (input bank, input new_tgl, input dout);
endinterface : xps_link_if

`default_nettype wire

// file: xps_shift.sv
// Serial shift bank, clocked by the controller's serial clock.
// Assumes chip select, data and mode are driven in step with that clock.
`timescale 1ns/1ps
`default_nettype none
`include "xps_map.svh"

module xps_shift
(
    input wire logic link_sclk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic din,
    input wire xps_pkg::xps_mode_e mode,
    xps_link_if.shifter lnk
);
    import xps_pkg::*;

    logic armed;
    logic [2:0] wcnt;
    logic [7:0] word;
    logic [7:0] next_word;
    logic shift_en;
    logic [`XPS_FRAME_BITS-2:0] bank_up;

    assign shift_en = !cs_n && armed;
    assign next_word = {din, word[7:1]};
    assign bank_up = lnk.bank[`XPS_FRAME_BITS-1:1];
    assign lnk.dout = lnk.bank[0]; // RULE19

    // =====================================================
    // Arming: rising edge after select falls
    always_ff @(posedge link_sclk or posedge cs_n)
    begin
        if (cs_n)
            armed <= 1'b0; // RULE1
        else
            armed <= 1'b1; // RULE2
    end

    // =====================================================
    // Addressed word assembly, falling edge only
    always_ff @(negedge link_sclk or posedge cs_n)
    begin
        if (cs_n)
            wcnt <= 3'h0;
        else if (shift_en && mode == XPS_MODE_ADDR)
            wcnt <= wcnt + 3'h1;
    end

    always_ff @(negedge link_sclk)
    begin
        if (shift_en)
            word <= next_word; // RULE3
    end

    // =====================================================
    // Shift bank and change toggle
    always_ff @(negedge link_sclk or negedge reset_n)
    begin
        if (!reset_n)
            lnk.bank <= {`XPS_N_OUT{`XPS_RST_ENTRY}}; // RULE20
        else if (shift_en && mode == XPS_MODE_SERIAL)
            lnk.bank <= {din, bank_up}; // RULE11 RULE15 RULE9
        else if (shift_en && wcnt == `XPS_WORD_LAST)
            lnk.bank[next_word[`XPS_AW_OUT_LSB +: 3] * `XPS_ENTRY_BITS +: `XPS_ENTRY_BITS]
                <= {din, next_word[`XPS_AW_IN_LSB +: `XPS_IN_BITS]}; // RULE10 RULE16
    end

    always_ff @(negedge link_sclk or negedge reset_n)
    begin
        if (!reset_n)
            lnk.new_tgl <= 1'b0;
        else if (shift_en && (mode == XPS_MODE_SERIAL || wcnt == `XPS_WORD_LAST))
            lnk.new_tgl <= ~lnk.new_tgl;
    end

    // =====================================================
    // Checks
    chk_idle_bank_hold: assert property ( // RULE1
        @(negedge link_sclk) disable iff (!reset_n)
        cs_n |=> $stable(lnk.bank))
        else $error("shift bank moved while select was high");

    chk_serial_shift_in: assert property ( // RULE3
        @(negedge link_sclk) disable iff (!reset_n)
        (shift_en && mode == XPS_MODE_SERIAL)
        |=> lnk.bank == {$past(din), $past(bank_up)})
        else $error("serial bit not shifted in on falling edge");

endmodule : xps_shift

`default_nettype wire

// file: xps_ctl_model.sv
// Behavioural serial controller that programs the crosspoint configuration pins.
// Assumes the bench calls its tasks one at a time; the link clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none

module xps_ctl_model
(
    output logic sclk,
    output logic cs_n,
    output logic din,
    output var xps_pkg::xps_mode_e mode
);
    import xps_pkg::*;

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        mode = XPS_MODE_SERIAL;
    end

    // =====================================================
    // One frame or word, bit 0 first, 48 ns clock only inside it
    task automatic send(input logic [39:0] bits, input int n, input xps_mode_e m,
                        input bit hold);
        mode = m;
        cs_n = 1'b0;
        // An empty call only releases select and gives no clock edge
        #24 sclk = (n > 0);
        for (int i = 0; i < n; i++)
        begin
            #4 din = bits[i];
            #20 sclk = 1'b0;
            #24 sclk = (i < n - 1);
        end
        if (!hold)
            cs_n = 1'b1;
        // Released data line shows no stale bit
        din = ~din;
        // Idle gap so a following call never reselects in the same step
        #24;
    endtask : send

    // =====================================================
    // Clock and data activity while deselected
    task automatic noise(input int n);
        for (int i = 0; i < n; i++)
        begin
            #24 sclk = 1'b1;
            din = 1'($urandom);
            #24 sclk = 1'b0;
        end
    endtask : noise

endmodule : xps_ctl_model

`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the crosspoint configuration logic.
// Assumes the controller model drives the serial pins on a 48 ns link clock.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import xps_pkg::*;

    logic clk_sys, reset_n, link_sclk, cs_n, din, cfg, shutdown, broadcast_input_zero;
    logic dout;
    xps_mode_e mode;
    logic [31:0] route_sel;
    logic [7:0] route_oe_n;
    logic [39:0] bank, cur;
    logic [7:0] w;
    int failures, checked;

    xps_crosspoint i_xps_crosspoint
    (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .link_sclk(link_sclk),
        .cs_n(cs_n),
        .din(din),
        .mode(mode),
        .cfg(cfg),
        .shutdown(shutdown),
        .broadcast_input_zero(broadcast_input_zero),
        .route_sel(route_sel),
        .route_oe_n(route_oe_n),
        .dout(dout)
    );

    // Single device on the bus: no output is joined to another chip
    xps_ctl_model i_xps_ctl_model
    (
        .sclk(link_sclk),
        .cs_n(cs_n),
        .din(din),
        .mode(mode)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // =====================================================
    // Expected {route_oe_n, route_sel} for a shift bank image
    function automatic logic [39:0] routes(input logic [39:0] f);
        logic [39:0] r;
        for (int k = 0; k < 8; k++)
        begin
            r[32 + k] = f[5*k + 4];
            r[4*k +: 4] = f[5*k +: 4];
        end
        return r;
    endfunction : routes

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic pulse_cfg;
        repeat (4) @(negedge clk_sys);
        cfg = 1'b1;
        repeat (3) @(negedge clk_sys);
        cfg = 1'b0;
        repeat (6) @(negedge clk_sys);
    endtask : pulse_cfg

    task automatic complete_run;
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // =====================================================
    // Main sequence
    initial
    begin
        failures = 0;
        checked = 0;
        reset_n = 1'b1;
        cfg = 1'b0;
        shutdown = 1'b0;
        broadcast_input_zero = 1'b0;
        void'($urandom(32'hC22A5A0C));
        // A real falling edge loads every shift bank entry with the off entry asynchronously
        #1 reset_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        check({route_oe_n, route_sel}, 40'hFF_0000_0000);
        check({39'h0, dout}, 40'h0);
        reset_n = 1'b1;
        cur = 40'hFF_0000_0000;
        // First frame routes input 15 to every output
        for (int t = 0; t < 5; t++)
        begin
            bank = (t == 0) ? 40'h7B_DEF7_BDEF : 40'({$urandom, $urandom});
            i_xps_ctl_model.send(bank, 40, XPS_MODE_SERIAL, 1'b0);
            check({39'h0, dout}, {39'h0, bank[0]});
            i_xps_ctl_model.noise(7);
            repeat (6) @(negedge clk_sys);
            check({route_oe_n, route_sel}, cur);
            pulse_cfg();
            cur = routes(bank);
            check({route_oe_n, route_sel}, cur);
            pulse_cfg();
            check({route_oe_n, route_sel}, cur);
        end
        // Addressed words, strobe given with chip select still low
        for (int t = 0; t < 6; t++)
        begin
            w = (t == 0) ? 8'h00 : ((t == 1) ? 8'hFF : 8'($urandom));
            i_xps_ctl_model.send({32'h0, w}, 8, XPS_MODE_ADDR, 1'b1);
            pulse_cfg();
            bank[5*w[2:0] +: 5] = {w[7], w[6:3]};
            check({route_oe_n, route_sel}, routes(bank));
            i_xps_ctl_model.send(40'h0, 0, XPS_MODE_ADDR, 1'b0);
        end
        // Overrides: shutdown wins, then broadcast, kept after release
        shutdown = 1'b1;
        broadcast_input_zero = 1'b1;
        repeat (5) @(negedge clk_sys);
        check({route_oe_n, route_sel}, 40'hFF_0000_0000);
        shutdown = 1'b0;
        repeat (5) @(negedge clk_sys);
        check({route_oe_n, route_sel}, 40'h0);
        broadcast_input_zero = 1'b0;
        pulse_cfg();
        check({route_oe_n, route_sel}, 40'h0);
        complete_run();
    end

    // =====================================================
    // Watchdog, about ten times the expected run
    initial
    begin
        #300000;
        failures++;
        complete_run();
    end

endmodule : tb_top

`default_nettype wire
